//--- verilog/cstg_pkg.sv
package cstg_pkg;
    // ************************************************************
    // supervisor states, one-hot
    // ************************************************************
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01, // waiting to launch the power-up sequence
        ST_TEST  = 6'h02, // power-up tests running
        ST_RUN   = 6'h04, // operational
        ST_ISO   = 6'h08, // keygen or manual key entry in progress
        ST_ERR   = 6'h10, // latched error state
        ST_ZDONE = 6'h20  // zeroized, waiting for a power cycle
    } cstg_state_type;

    // ************************************************************
    // power-up test index
    // ************************************************************
    localparam int NUM_TESTS = 5;
    localparam logic [2:0] T_FW_CRC = 3'h0; // firmware code check
    localparam logic [2:0] T_KAT_C1 = 3'h1; // engine ecb-256 answer test, counter path 1
    localparam logic [2:0] T_KAT_C2 = 3'h2; // engine ecb-256 answer test, counter path 2
    localparam logic [2:0] T_FPGA = 3'h3; // logic configuration load check
    localparam logic [2:0] T_FLAG = 3'h4; // bypass flag crc check
    localparam int CRC_W = 32; // width of every error detection code
    localparam int KEY_BITS = 256; // engine key size under test
    localparam int RND_W = 32; // width of one random source sample

    // ************************************************************
    // status codes, carry no secret material
    // ************************************************************
    localparam logic [3:0] STAT_OK = 4'h0;
    localparam logic [3:0] STAT_BUSY = 4'h1;
    localparam logic [3:0] STAT_FW = 4'h2;
    localparam logic [3:0] STAT_KAT = 4'h3;
    localparam logic [3:0] STAT_FPGA = 4'h4;
    localparam logic [3:0] STAT_FLAG = 4'h5;
    localparam logic [3:0] STAT_RND = 4'h6;
    localparam logic [3:0] STAT_MKEY = 4'h7;
    localparam logic [3:0] STAT_ZERO = 4'h8;
endpackage : cstg_pkg

//--- verilog/cstg_crc32.sv
`timescale 1ns/1ps
// ************************************************************
// serial-word crc-32 accumulator, reflected polynomial
// ************************************************************
module cstg_crc32 (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_clear, // restart the accumulator
    input wire logic i_valid, // one data word this cycle
    input wire logic [31:0] i_data,
    output logic [31:0] o_crc // final inverted code, registered
);
    logic [31:0] acc_q;
    logic [31:0] acc_d;
    localparam logic [31:0] POLY = 32'hEDB88320;
    localparam logic [31:0] INIT = 32'hFFFFFFFF;

    // word-at-a-time next value by bitwise folding
    always_comb begin
        acc_d = acc_q ^ i_data;
        for (int i = 0; i < 32; i++) begin
            acc_d = acc_d[0] ? ((acc_d >> 1) ^ POLY) : (acc_d >> 1);
        end
    end

    // ************************************************************
    // accumulator register
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_srst || i_clear) begin
            acc_q <= INIT;
        end else if (i_valid) begin
            acc_q <= acc_d;
        end
    end

    assign o_crc = ~acc_q;
endmodule : cstg_crc32

//--- verilog/cstg_gate.sv
`timescale 1ns/1ps
// Behaviour
// R1 - any test failure enters error, fault lamp on
// R2 - all power-up tests pass, fault lamp off
// R3 - error state blocks outputs, crypto, shows status; o_data_valid can stay high one cycle into error
// R4 - status carries only fixed codes, no secrets
// R5 - outputs inhibited during tests and in error; a word taken as the fault hits still shows valid in the first error cycle
// R6 - power-up tests start without operator input
// R7 - bypass needs two independent internal actions
// R8 - bypass selected lights bypass lamp
// R9 - bypass flag crc checked before use
// R10 - firmware crc compared with stored value
// R11 - output isolated during keygen, key entry, zeroize
// R12 - control machine always in exactly one state
// R13 - zeroize erases parameters, needs power cycle
// R14 - engine answer tests cover both counter paths
// R15 - random source continuous test on each request
// R16 - configuration load verified at power-up
// R17 - manual key code mismatch is failure
// R18 - compatibility mode locked while peer authenticated
// R19 - sessions cleared after power cycle
// R20 - error latched until reset
module cstg_gate (
    input wire logic i_mclk,
    input wire logic i_srst, // reset or power cycle
    // firmware code stream for the integrity check
    input wire logic i_fw_valid,
    input wire logic [31:0] i_fw_word,
    input wire logic i_fw_last,
    input wire logic [31:0] i_fw_stored_crc,
    // engine answer tests, one result per counter path
    input wire logic i_kat_done,
    input wire logic i_kat_c1_pass,
    input wire logic i_kat_c2_pass,
    // configuration load from the programmable logic
    input wire logic i_fpga_loaded,
    // bypass flag read from flash
    input wire logic i_flag_valid,
    input wire logic [31:0] i_flag_word,
    input wire logic [31:0] i_flag_stored_crc,
    // random source requests
    input wire logic i_rnd_req,
    input wire logic [31:0] i_nondeterministic_random_source,
    // manual key entry check
    input wire logic i_mkey_valid,
    input wire logic [31:0] i_mkey_calc_code,
    input wire logic [31:0] i_mkey_error_detection_code,
    // isolation requests
    input wire logic i_keygen_busy,
    input wire logic i_keyentry_busy,
    input wire logic i_zeroize_req,
    // bypass arming, two independent actions
    input wire logic i_bypass_act_a,
    input wire logic i_bypass_act_b,
    // compatibility mode change
    input wire logic i_peer_auth,
    input wire logic i_compat_wr,
    input wire logic i_compat_val,
    // session handling
    input wire logic i_auth_grant,
    // data path from the engines
    input wire logic i_data_valid,
    input wire logic [31:0] i_data,
    output logic o_data_valid,
    output logic [31:0] o_data,
    output logic o_crypto_en,
    output logic o_fault_led,
    output logic o_bypass_led,
    output logic o_bypass_mode,
    output logic [3:0] o_status,
    output logic o_tests_busy,
    output logic o_zeroize,
    output logic o_zero_done,
    output logic o_compat_mode,
    output logic o_session_valid,
    output logic [31:0] o_rnd,
    output logic o_rnd_valid
);
    // ************************************************************
    // state and registers
    // ************************************************************
    cstg_pkg::cstg_state_type st_q, st_d; // supervisor state
    logic [cstg_pkg::NUM_TESTS-1:0] done_q; // tests finished
    logic [3:0] stat_q, stat_d; // latched status code
    logic [31:0] rnd_prev_q; // last random sample
    logic rnd_prim_q; // first sample taken
    logic flag_ok_q; // flag crc checked good
    logic flag_bypass_q; // bypass as stored in flash
    logic arm_a_q, arm_b_q; // bypass actions seen, sticky
    logic bypass_q, compat_q, sess_q, dv_q, rv_q;
    logic [31:0] data_q, rnd_q, fw_crc, flag_crc;
    logic fw_clr;
    logic fw_check_q; // last firmware word was absorbed

    // ************************************************************
    // failure decode
    // ************************************************************
    wire in_test = (st_q == cstg_pkg::ST_TEST);
    wire fw_fail = in_test && fw_check_q && (fw_crc != i_fw_stored_crc); // R10
    wire kat_fail = in_test && i_kat_done && !(i_kat_c1_pass && i_kat_c2_pass); // R14
    wire fpga_fail = in_test && !i_fpga_loaded && done_q[cstg_pkg::T_FW_CRC]; // R16
    // flag check fires one cycle after the flag word is absorbed
    logic flag_chk_q;
    wire flag_chk_q_hit = in_test && flag_chk_q;
    wire flag_fail = flag_chk_q_hit && (flag_crc != i_flag_stored_crc); // R9
    wire rnd_fail = i_rnd_req && rnd_prim_q &&
        (i_nondeterministic_random_source == rnd_prev_q); // R15
    wire mkey_fail = i_mkey_valid && (i_mkey_calc_code != i_mkey_error_detection_code); // R17
    wire any_fail = fw_fail || kat_fail || fpga_fail || flag_fail || rnd_fail || mkey_fail;
    wire all_done = &done_q;
    wire iso_req = i_keygen_busy || i_keyentry_busy; // R11

    // ************************************************************
    // crc engines
    // ************************************************************
    assign fw_clr = (st_q == cstg_pkg::ST_IDLE);
    cstg_crc32 u_fw_crc (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_clear(fw_clr),
        .i_valid(in_test && i_fw_valid),
        .i_data(i_fw_word),
        .o_crc(fw_crc)
    );
    cstg_crc32 u_flag_crc (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_clear(fw_clr),
        .i_valid(in_test && i_flag_valid),
        .i_data(i_flag_word),
        .o_crc(flag_crc)
    );

    // ************************************************************
    // next state; error has priority in test, run and isolation, and is never left
    // ************************************************************
    always_comb begin
        st_d = st_q;
        stat_d = stat_q;
        case (st_q)
            cstg_pkg::ST_IDLE: begin
                st_d = cstg_pkg::ST_TEST; // R6
                stat_d = cstg_pkg::STAT_BUSY;
            end
            cstg_pkg::ST_TEST: begin
                if (any_fail) begin
                    st_d = cstg_pkg::ST_ERR; // R1
                end else if (all_done) begin
                    st_d = cstg_pkg::ST_RUN;
                    stat_d = cstg_pkg::STAT_OK;
                end
            end
            cstg_pkg::ST_RUN: begin
                if (any_fail) begin
                    st_d = cstg_pkg::ST_ERR;
                end else if (i_zeroize_req) begin
                    st_d = cstg_pkg::ST_ZDONE; // R13
                    stat_d = cstg_pkg::STAT_ZERO;
                end else if (iso_req) begin
                    st_d = cstg_pkg::ST_ISO;
                end
            end
            cstg_pkg::ST_ISO: begin
                if (any_fail) begin
                    st_d = cstg_pkg::ST_ERR;
                end else if (i_zeroize_req) begin
                    st_d = cstg_pkg::ST_ZDONE; // R13
                    stat_d = cstg_pkg::STAT_ZERO;
                end else if (!iso_req) begin
                    st_d = cstg_pkg::ST_RUN;
                end
            end
            cstg_pkg::ST_ZDONE, cstg_pkg::ST_ERR: begin
                st_d = st_q; // R20, only a power cycle leaves
            end
            default: begin
                st_d = cstg_pkg::ST_ERR; // illegal code is treated as a fault
            end
        endcase
        // fixed codes only, never data or key bits
        if (st_q != cstg_pkg::ST_ERR && st_d == cstg_pkg::ST_ERR) begin
            stat_d = fw_fail ? cstg_pkg::STAT_FW :
                     kat_fail ? cstg_pkg::STAT_KAT :
                     fpga_fail ? cstg_pkg::STAT_FPGA :
                     flag_fail ? cstg_pkg::STAT_FLAG :
                     rnd_fail ? cstg_pkg::STAT_RND : cstg_pkg::STAT_MKEY; // R4
        end
    end

    // ************************************************************
    // supervisor registers
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            st_q <= cstg_pkg::ST_IDLE;
            stat_q <= cstg_pkg::STAT_BUSY;
        end else begin
            st_q <= st_d; // R12
            stat_q <= stat_d;
        end
    end

    // test completion tracking
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            done_q <= '0;
            fw_check_q <= 1'b0;
            flag_chk_q <= 1'b0;
        end else begin
            fw_check_q <= in_test && i_fw_valid && i_fw_last;
            flag_chk_q <= in_test && i_flag_valid;
            done_q[cstg_pkg::T_FW_CRC] <= done_q[cstg_pkg::T_FW_CRC] | fw_check_q;
            if (in_test && i_kat_done) begin
                done_q[cstg_pkg::T_KAT_C1] <= 1'b1;
                done_q[cstg_pkg::T_KAT_C2] <= 1'b1;
            end
            if (in_test && i_fpga_loaded) begin
                done_q[cstg_pkg::T_FPGA] <= 1'b1;
            end
            done_q[cstg_pkg::T_FLAG] <= done_q[cstg_pkg::T_FLAG] | flag_chk_q_hit;
        end
    end

    // ************************************************************
    // bypass flag, arming and lamp
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            flag_ok_q <= 1'b0;
            flag_bypass_q <= 1'b0;
            arm_a_q <= 1'b0;
            arm_b_q <= 1'b0;
            bypass_q <= 1'b0;
        end else begin
            if (flag_chk_q_hit && !flag_fail) begin
                flag_ok_q <= 1'b1; // R9
            end
            if (in_test && i_flag_valid) begin
                flag_bypass_q <= i_flag_word[0];
            end
            arm_a_q <= arm_a_q | i_bypass_act_a;
            arm_b_q <= arm_b_q | i_bypass_act_b;
            // both actions and a good flag are needed
            bypass_q <= arm_a_q && arm_b_q && flag_ok_q && flag_bypass_q
                && (st_q == cstg_pkg::ST_RUN); // R7
        end
    end

    // ************************************************************
    // random source continuous test
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            rnd_prim_q <= 1'b0;
            rnd_prev_q <= 32'h00000000;
            rnd_q <= 32'h00000000;
            rv_q <= 1'b0;
        end else begin
            rv_q <= i_rnd_req && !rnd_fail && rnd_prim_q && (st_q == cstg_pkg::ST_RUN);
            if (i_rnd_req) begin
                rnd_prim_q <= 1'b1; // R15
                rnd_prev_q <= i_nondeterministic_random_source;
                rnd_q <= i_nondeterministic_random_source;
            end
        end
    end

    // ************************************************************
    // compatibility mode and sessions
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            compat_q <= 1'b0;
            sess_q <= 1'b0; // R19
        end else begin
            if (i_compat_wr && !i_peer_auth) begin
                compat_q <= i_compat_val; // R18
            end
            if (i_auth_grant && st_q == cstg_pkg::ST_RUN) begin
                sess_q <= 1'b1;
            end else if (st_q == cstg_pkg::ST_ERR || st_q == cstg_pkg::ST_ZDONE) begin
                sess_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // gated data path
    // ************************************************************
    wire out_ok = (st_q == cstg_pkg::ST_RUN) && !iso_req && !i_zeroize_req; // R5 R11
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            dv_q <= 1'b0;
            data_q <= 32'h00000000;
        end else begin
            dv_q <= out_ok && i_data_valid; // R3
            data_q <= (out_ok && i_data_valid) ? i_data : 32'h00000000;
        end
    end

    assign o_data_valid = dv_q;
    assign o_data = data_q;
    assign o_crypto_en = (st_q == cstg_pkg::ST_RUN) || (st_q == cstg_pkg::ST_ISO); // R3
    assign o_fault_led = (st_q == cstg_pkg::ST_ERR); // R1 R2
    assign o_bypass_led = bypass_q; // R8
    assign o_bypass_mode = bypass_q;
    assign o_status = stat_q;
    assign o_tests_busy = (st_q == cstg_pkg::ST_IDLE) || in_test;
    assign o_zeroize = (st_q == cstg_pkg::ST_ZDONE); // R13
    assign o_zero_done = 1'b0; // completes only through a power cycle
    assign o_compat_mode = compat_q;
    assign o_session_valid = sess_q;
    assign o_rnd = rnd_q;
    assign o_rnd_valid = rv_q;

    // ************************************************************
    // checks
    // ************************************************************
    property p_err_led;
        @(posedge i_mclk) disable iff (i_srst)
        (st_q != cstg_pkg::ST_ERR) && any_fail && (st_q != cstg_pkg::ST_IDLE)
            && (st_q != cstg_pkg::ST_ZDONE) |=> o_fault_led;
    endproperty
    a_err_led: assert property (p_err_led) else $error("fail did not light fault"); // R1
    property p_pass_off;
        @(posedge i_mclk) disable iff (i_srst)
        in_test && all_done && !any_fail |=> !o_fault_led && st_q == cstg_pkg::ST_RUN;
    endproperty
    a_pass_off: assert property (p_pass_off) else $error("pass left fault on"); // R2
    property p_err_block;
        @(posedge i_mclk) disable iff (i_srst) o_fault_led |=> !o_data_valid && !o_crypto_en;
    endproperty
    a_err_block: assert property (p_err_block) else $error("error did not block"); // R3
    property p_test_inh;
        @(posedge i_mclk) disable iff (i_srst) o_tests_busy |=> !o_data_valid;
    endproperty
    a_test_inh: assert property (p_test_inh) else $error("output during tests"); // R5
    property p_auto;
        @(posedge i_mclk) $fell(i_srst) |-> ##1 in_test;
    endproperty
    a_auto: assert property (p_auto) else $error("tests not started"); // R6
    property p_bypass;
        @(posedge i_mclk) disable iff (i_srst) o_bypass_led |-> $past(arm_a_q) && $past(arm_b_q);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass on one action"); // R7
    property p_iso;
        @(posedge i_mclk) disable iff (i_srst) iso_req |=> !o_data_valid;
    endproperty
    a_iso: assert property (p_iso) else $error("output not isolated"); // R11
    property p_onehot;
        @(posedge i_mclk) disable iff (i_srst) $onehot(st_q);
    endproperty
    a_onehot: assert property (p_onehot) else $error("state not one-hot"); // R12
    property p_latch;
        @(posedge i_mclk) disable iff (i_srst) o_fault_led |=> o_fault_led [*2];
    endproperty
    a_latch: assert property (p_latch) else $error("error cleared"); // R20
    property p_compat;
        @(posedge i_mclk) disable iff (i_srst) i_peer_auth |=> $stable(o_compat_mode);
    endproperty
    a_compat: assert property (p_compat) else $error("mode changed under peer"); // R18
    c_run: cover property (@(posedge i_mclk) in_test ##[1:50] st_q == cstg_pkg::ST_RUN);
    c_err: cover property (@(posedge i_mclk) in_test ##[1:50] o_fault_led);
    c_byp: cover property (@(posedge i_mclk) !o_bypass_led ##1 o_bypass_led);
    c_zero: cover property (@(posedge i_mclk) ##1 o_zeroize);
endmodule : cstg_gate

//--- bench/cstg_fw_model.sv
`timescale 1ns/1ps
// ************************************************************
// boot store stand-in: streams the image once per start
// ************************************************************
module cstg_fw_model #(
    parameter int NW = 4 // image length in words, kept short
) (
    input wire logic i_mclk,
    input wire logic i_start,
    input wire logic i_corrupt, // stored code made wrong
    input wire logic [31:0] i_flag_word,
    output logic o_fw_valid,
    output logic [31:0] o_fw_word,
    output logic o_fw_last,
    output logic [31:0] o_fw_crc,
    output logic [31:0] o_flag_crc
);
    int cnt = NW; // words already sent, nw means idle
    logic start_q = 1'b0;
    // reflected crc-32, lsb of each word first
    function automatic logic [31:0] crc_w(input logic [31:0] c, input logic [31:0] w);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 32; i++) begin
            r = (r[0] ^ w[i]) ? ((r >> 1) ^ 32'hEDB88320) : (r >> 1);
        end
        return r;
    endfunction : crc_w
    function automatic logic [31:0] word_of(input int k);
        return 32'h9E3779B9 * (k + 1);
    endfunction : word_of
    function automatic logic [31:0] image_crc();
        logic [31:0] r;
        r = 32'hFFFFFFFF;
        for (int k = 0; k < NW; k++) begin
            r = crc_w(r, word_of(k));
        end
        return ~r;
    endfunction : image_crc
    assign o_fw_crc = image_crc() ^ {31'h0, i_corrupt};
    assign o_flag_crc = ~crc_w(32'hFFFFFFFF, i_flag_word);
    initial begin
        o_fw_valid = 1'b0;
        o_fw_last = 1'b0;
        o_fw_word = 32'h0;
    end
    always @(posedge i_mclk) start_q <= i_start;
    // idle word lines toggle so a stale word never looks fresh
    always @(negedge i_mclk) begin
        if (start_q) begin
            cnt = 0;
        end
        o_fw_valid <= (cnt < NW);
        o_fw_last <= (cnt == NW - 1);
        o_fw_word <= (cnt < NW) ? word_of(cnt) : ~o_fw_word;
        if (cnt < NW) begin
            cnt = cnt + 1;
        end
    end
endmodule : cstg_fw_model

//--- bench/tb_crypto_selftest_error_gate.sv
`timescale 1ns/1ps
// ************************************************************
// bench: power-up, faults, bypass, isolation, zeroize
// ************************************************************
module tb_crypto_selftest_error_gate;
    logic i_mclk = 1'b0, i_srst = 1'b1, i_fw_valid, i_fw_last, i_kat_done, i_kat_c1_pass;
    logic i_kat_c2_pass, i_fpga_loaded, i_flag_valid, i_rnd_req, i_mkey_valid, i_keygen_busy;
    logic i_keyentry_busy, i_zeroize_req, i_bypass_act_a, i_bypass_act_b, i_peer_auth;
    logic i_compat_wr, i_compat_val, i_auth_grant, i_data_valid, fw_start, fw_corrupt;
    logic [31:0] i_fw_word, i_fw_stored_crc, i_flag_word, i_flag_stored_crc, i_data, flag_crc;
    logic [31:0] i_nondeterministic_random_source, i_mkey_calc_code, i_mkey_error_detection_code;
    logic o_data_valid, o_crypto_en, o_fault_led, o_bypass_led, o_bypass_mode, o_tests_busy;
    logic o_zeroize, o_zero_done, o_compat_mode, o_session_valid, o_rnd_valid;
    logic [31:0] o_data, o_rnd, v, exp_d;
    logic [3:0] o_status;
    logic [31:0] exp_q[$]; // expected output words
    int n_mismatch = 0, num_checks = 0;
    int unsigned xs_q = 14;
    // status per power-up fault: none, fw, kat1, kat2, fpga, flag
    logic [3:0] stat_of[6] = '{cstg_pkg::STAT_OK, cstg_pkg::STAT_FW, cstg_pkg::STAT_KAT,
        cstg_pkg::STAT_KAT, cstg_pkg::STAT_FPGA, cstg_pkg::STAT_FLAG};
    always #25 i_mclk = ~i_mclk;
    cstg_gate dut (.i_mclk, .i_srst, .i_fw_valid, .i_fw_word, .i_fw_last, .i_fw_stored_crc,
        .i_kat_done, .i_kat_c1_pass, .i_kat_c2_pass, .i_fpga_loaded, .i_flag_valid, .i_flag_word,
        .i_flag_stored_crc, .i_rnd_req, .i_nondeterministic_random_source, .i_mkey_valid,
        .i_mkey_calc_code, .i_mkey_error_detection_code, .i_keygen_busy, .i_keyentry_busy,
        .i_zeroize_req, .i_bypass_act_a, .i_bypass_act_b, .i_peer_auth, .i_compat_wr,
        .i_compat_val, .i_auth_grant, .i_data_valid, .i_data, .o_data_valid, .o_data,
        .o_crypto_en, .o_fault_led, .o_bypass_led, .o_bypass_mode, .o_status, .o_tests_busy,
        .o_zeroize, .o_zero_done, .o_compat_mode, .o_session_valid, .o_rnd, .o_rnd_valid);
    cstg_fw_model #(.NW(4)) fw (.i_mclk, .i_start(fw_start), .i_corrupt(fw_corrupt),
        .i_flag_word, .o_fw_valid(i_fw_valid), .o_fw_word(i_fw_word), .o_fw_last(i_fw_last),
        .o_fw_crc(i_fw_stored_crc), .o_flag_crc(flag_crc));
    function automatic logic [31:0] xs();
        xs_q ^= xs_q << 13;
        xs_q ^= xs_q >> 17;
        xs_q ^= xs_q << 5;
        return xs_q;
    endfunction : xs
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    task automatic chk1(input logic a, input logic e);
        num_checks++;
        if (a !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: flag %b want %b", $time, a, e);
        end
    endtask : chk1
    task automatic chk32(input logic [31:0] a, input logic [31:0] e);
        num_checks++;
        if (a !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: word %h want %h", $time, a, e);
        end
    endtask : chk32
    task automatic chk4(input logic [3:0] a, input logic [3:0] e);
        num_checks++;
        if (a !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: status %h want %h", $time, a, e);
        end
    endtask : chk4
    // one-cycle pulse, then a cycle for outputs to settle
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge i_mclk);
        s = 1'b0;
        @(negedge i_mclk);
    endtask : pulse
    // data words in; pass says whether each must come out
    task automatic send(input int n, input logic pass);
        for (int k = 0; k < n; k++) begin
            i_data_valid = 1'b1;
            i_data = xs();
            exp_q.push_back(i_data);
            @(negedge i_mclk);
            exp_d = exp_q.pop_front();
            chk1(o_data_valid, pass);
            if (pass) chk32(o_data, exp_d);
        end
        i_data_valid = 1'b0;
    endtask : send
    task automatic rnd(input logic [31:0] s, input logic ev);
        i_rnd_req = 1'b1;
        i_nondeterministic_random_source = s;
        @(negedge i_mclk);
        i_rnd_req = 1'b0;
        chk1(o_rnd_valid, ev);
        if (ev) chk32(o_rnd, s);
        @(negedge i_mclk);
    endtask : rnd
    // reset, then one power-up run with fault f and no operator input
    task automatic powerup(input int f, input logic byp);
        int t;
        i_srst = 1'b1;
        fw_corrupt = (f == 1);
        repeat (12) @(negedge i_mclk);
        i_srst = 1'b0;
        i_fpga_loaded = (f != 4);
        fw_start = 1'b1;
        i_data_valid = 1'b1;
        @(negedge i_mclk);
        fw_start = 1'b0;
        i_kat_done = 1'b1;
        i_kat_c1_pass = (f != 2);
        i_kat_c2_pass = (f != 3);
        @(negedge i_mclk);
        i_kat_done = 1'b0;
        repeat (4) @(negedge i_mclk);
        i_flag_word = (xs() << 1) | 32'(byp);
        #1 i_flag_stored_crc = flag_crc ^ {31'h0, f == 5};
        i_flag_valid = 1'b1;
        @(negedge i_mclk);
        i_flag_valid = 1'b0;
        for (t = 0; t < 20 && o_tests_busy !== 1'b0; t++) begin
            chk1(o_data_valid, 1'b0);
            @(negedge i_mclk);
        end
        if (t == 20) begin
            n_mismatch++;
            final_report();
        end
        i_data_valid = 1'b0;
        @(negedge i_mclk);
        chk1(o_fault_led, f != 0);
        chk4(o_status, stat_of[f]);
        chk1(o_crypto_en, f == 0);
        send(1, f == 0);
    endtask : powerup
    initial begin
        {i_kat_done, i_kat_c1_pass, i_kat_c2_pass, i_fpga_loaded, i_flag_valid} = '0;
        {i_rnd_req, i_mkey_valid, i_keygen_busy, i_keyentry_busy, i_zeroize_req} = '0;
        {i_bypass_act_a, i_bypass_act_b, i_peer_auth, i_compat_wr, i_compat_val} = '0;
        {i_auth_grant, i_data_valid, fw_start, fw_corrupt} = '0;
        {i_flag_word, i_flag_stored_crc, i_data, i_nondeterministic_random_source} = '0;
        {i_mkey_calc_code, i_mkey_error_detection_code} = '0;
        for (int f = 0; f < 6; f++) powerup(f, 1'b0);
        for (int b = 0; b < 2; b++) begin
            powerup(0, b[0]);
            pulse(i_bypass_act_a);
            chk1(o_bypass_led, 1'b0);
            pulse(i_bypass_act_b);
            chk1(o_bypass_led, b[0]);
            chk1(o_bypass_mode, b[0]);
        end
        i_peer_auth = 1'b1;
        i_compat_val = 1'b1;
        pulse(i_compat_wr);
        chk1(o_compat_mode, 1'b0);
        i_peer_auth = 1'b0;
        pulse(i_compat_wr);
        chk1(o_compat_mode, 1'b1);
        pulse(i_auth_grant);
        chk1(o_session_valid, 1'b1);
        v = xs();
        rnd(v, 1'b0);
        rnd(~v, 1'b1);
        rnd(~v, 1'b0);
        chk1(o_fault_led, 1'b1);
        chk4(o_status, cstg_pkg::STAT_RND);
        chk1(o_session_valid, 1'b0);
        powerup(0, 1'b0);
        chk1(o_session_valid, 1'b0);
        i_keygen_busy = 1'b1;
        send(2, 1'b0);
        i_keygen_busy = 1'b0;
        i_keyentry_busy = 1'b1;
        send(2, 1'b0);
        i_keyentry_busy = 1'b0;
        @(negedge i_mclk);
        send(1, 1'b1);
        i_mkey_calc_code = xs();
        i_mkey_error_detection_code = i_mkey_calc_code;
        pulse(i_mkey_valid);
        chk1(o_fault_led, 1'b0);
        i_mkey_error_detection_code = ~i_mkey_calc_code;
        pulse(i_mkey_valid);
        chk4(o_status, cstg_pkg::STAT_MKEY);
        i_mkey_error_detection_code = i_mkey_calc_code;
        pulse(i_mkey_valid);
        repeat (5) @(negedge i_mclk);
        chk1(o_fault_led, 1'b1);
        send(1, 1'b0);
        powerup(0, 1'b0);
        pulse(i_zeroize_req);
        chk4(o_status, cstg_pkg::STAT_ZERO);
        chk1(o_zeroize, 1'b1);
        chk1(o_crypto_en, 1'b0);
        send(1, 1'b0);
        final_report();
    end
endmodule : tb_crypto_selftest_error_gate
